// >>> bench/test_ucgen_clock_gen.sv
// testbench: clock generator modes, rates and power gating
`timescale 1ns/100ps
module test_ucgen_clock_gen;
	logic	mclk, srst, lo_wr, hi_wr, run, pin, pout, poe, rclk, tchg;
	logic [7:0]	wd;
	logic [11:0]	bdiv, n;
	ucgen_pkg::ucg_cfg_type	cfg;
	ucgen_pkg::ucg_ticks_type	ticks;
	ucgen_pkg::ucg_mode_type	mode;
	int	fails, checks, cyc, last, ntx, m, t;
	int	q[$];
	assign pin = poe ? pout : rclk;
	ucgen_clock_gen dut (.mclk, .srst, .cfg, .wr_data(wd), .baud_divisor_low_wr(lo_wr),
		.baud_divisor_high_wr(hi_wr), .xfer_clk_pin_in(pin), .xfer_clk_pin_out(pout),
		.xfer_clk_pin_oe(poe), .ticks, .mode, .tx_change_tick(tchg), .baud_divisor(bdiv));
	ucgen_remote_clk rem (.run, .idle_lvl(cfg.clk_polarity_bit), .clk_out(rclk));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t value %0d expected %0d", $time, g, e);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (ticks.tx_bit_tick === 1'b1) begin
			ntx = ntx + 1;
			cmp(1, tchg);
			if (q.size() > 0)
				cmp(q.pop_front(), cyc - last);
			last = cyc;
		end
	end
	task automatic setdiv(input logic [11:0] v);
		wd = {4'h0, v[11:8]};
		hi_wr = 1'b1;
		@(posedge mclk) #1;
		wd = v[7:0];
		hi_wr = 1'b0;
		lo_wr = 1'b1;
		@(posedge mclk) #1;
		lo_wr = 1'b0;
	endtask
	task automatic gaps(input int e);
		int k;
		int w;
		k = 0;
		w = ntx + 2;
		while (ntx < w && k < 9000) begin
			@(posedge mclk) #1;
			k++;
		end
		repeat (3) q.push_back(e);
		while (q.size() > 0 && k < 9000) begin
			@(posedge mclk) #1;
			k++;
		end
		if (k >= 9000) begin
			fails++;
			end_of_test();
		end
	endtask
	initial begin
		{cfg, wd, lo_wr, hi_wr, run, srst} = {5'h00, 8'h00, 3'h0, 1'b1};
		{fails, checks, cyc, last, ntx} = '0;
		void'($urandom(8711));
		repeat (10) @(posedge mclk);
		#1 srst = 1'b0;
		for (int i = 0; i < 6; i++) begin
			m = i % 3;
			n = 12'($urandom_range(15));
			cfg = {m == 2, m == 1 || i == 5, m == 2, i > 2, 1'b0};
			setdiv(n);
			cmp(n, bdiv);
			gaps((m == 0 ? 16 : (m == 1 ? 8 : 2)) * (int'(n) + 1));
			cmp(m == 2, poe);
		end
		setdiv(12'h100);
		gaps(514);
		run = 1'b1;
		for (int p = 0; p < 2; p++) begin
			cfg = {3'h4, p[0], 1'b0};
			gaps(18);
		end
		run = 1'b0;
		cfg = 5'h15;
		t = ntx;
		repeat (300) @(posedge mclk) #1;
		cmp(t, ntx);
		cmp(0, poe);
		end_of_test();
	end
endmodule

// >>> bench/ucgen_chk.sv
// checker: port properties of the clock generator
`timescale 1ns/100ps
module ucgen_chk (
	// clock and reset
	input wire logic	mclk,
	input wire logic	srst,
	// control
	input wire ucgen_pkg::ucg_cfg_type	cfg,
	input wire logic	baud_divisor_low_wr,
	input wire logic	baud_divisor_high_wr,
	// pin and ticks
	input wire logic	xfer_clk_pin_in,
	input wire logic	xfer_clk_pin_oe,
	input wire ucgen_pkg::ucg_ticks_type	ticks,
	input wire ucgen_pkg::ucg_mode_type	mode,
	input wire logic [11:0]	baud_divisor
);
	logic [12:0]	gap_r;
	logic [4:0]	tb_r, rb_r, f;
	logic	bd_r, td_r, rd_r, wr_r, wr, pwr, sl, pe;
	logic [1:0]	m, m_r;
	assign m = mode;
	assign pwr = cfg.serial_power_off_bit;
	assign wr = baud_divisor_low_wr | baud_divisor_high_wr;
	assign sl = m == 2'h3 && !pwr;
	assign pe = xfer_clk_pin_in ^ cfg.clk_polarity_bit;
	assign f = m[1] ? 5'h02 : (m[0] ? 5'h08 : 5'h10);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	always_ff @(posedge mclk) begin
		m_r <= m;
		wr_r <= wr;
		gap_r <= ticks.baud_tick ? 13'h0001 : gap_r + 13'h0001;
		bd_r <= srst | wr | wr_r | pwr | (bd_r & ~ticks.baud_tick);
		td_r <= srst | pwr | (m != m_r) | (td_r & ~ticks.tx_bit_tick);
		rd_r <= srst | pwr | (m != m_r) | (rd_r & ~ticks.rx_sample_tick);
		tb_r <= ticks.tx_bit_tick ? 5'h00 : tb_r + 5'(ticks.baud_tick);
		rb_r <= ticks.rx_sample_tick ? 5'h00 : rb_r + 5'(ticks.baud_tick);
	end
	AST_MODE: assert property (
		m == {cfg.sync_select_bit, cfg.sync_select_bit ? ~cfg.xfer_clk_dir_bit
			: cfg.double_speed_bit}) else $error("mode decode wrong");
	AST_OE: assert property (
		xfer_clk_pin_oe == (m == 2'h2 && !pwr)) else $error("pin enable wrong");
	AST_PWR: assert property (pwr [*2] |-> !ticks.baud_tick && !ticks.tx_bit_tick
		&& !ticks.rx_sample_tick) else $error("tick while powered off");
	AST_BAUD: assert property (ticks.baud_tick && !bd_r |->
		gap_r == {1'b0, baud_divisor} + 13'h0001) else $error("baud period wrong");
	AST_TX: assert property (ticks.tx_bit_tick && !td_r && m != 2'h3 |->
		tb_r + 5'(ticks.baud_tick) == f) else $error("tx division wrong");
	AST_RX: assert property (ticks.rx_sample_tick && !rd_r && m != 2'h3 |->
		rb_r + 5'(ticks.baud_tick) == f) else $error("rx division wrong");
	AST_SL_TX: assert property (sl && $changed(xfer_clk_pin_in) && pe
		|-> ##[1:4] ticks.tx_bit_tick) else $error("slave change edge missed");
	AST_SL_RX: assert property (sl && $changed(xfer_clk_pin_in) && !pe
		|-> ##[1:4] ticks.rx_sample_tick) else $error("slave sample edge missed");
	AST_MS_RX: assert property (m == 2'h2 && !pwr && $changed(xfer_clk_pin_in) && !pe
		|-> ticks.rx_sample_tick) else $error("master sample edge wrong");
endmodule
bind ucgen_clock_gen ucgen_chk u_chk (.mclk, .srst, .cfg, .baud_divisor_low_wr,
	.baud_divisor_high_wr, .xfer_clk_pin_in, .xfer_clk_pin_oe, .ticks, .mode, .baud_divisor);

// >>> bench/ucgen_remote_clk.sv
// remote transfer clock source for slave mode
`timescale 1ns/100ps
module ucgen_remote_clk (
	// control
	input wire logic	run,
	input wire logic	idle_lvl,
	// transfer clock
	output logic	clk_out
);
	initial begin
		clk_out = 1'b0;
		forever begin
			#13;
			if (run) begin
				clk_out = ~clk_out; // 18 cycle period, below a quarter of mclk
			end else begin
				clk_out = idle_lvl; // stands at idle level between frames
			end
			#437;
		end
	end
endmodule

// >>> src/ucgen_clock_gen.sv
// serial transfer clock generator: baud counter, dividers, sync clock pin
`timescale 1ns/100ps
module ucgen_clock_gen (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   srst,
	// configuration
	input  wire ucgen_pkg::ucg_cfg_type cfg,
	// divisor byte writes
	input  wire logic [7:0]             wr_data,
	input  wire logic                   baud_divisor_low_wr,
	input  wire logic                   baud_divisor_high_wr,
	// transfer clock pin
	input  wire logic                   xfer_clk_pin_in,
	output logic                        xfer_clk_pin_out,
	output logic                        xfer_clk_pin_oe,
	// tick outputs
	output ucgen_pkg::ucg_ticks_type    ticks,
	output ucgen_pkg::ucg_mode_type     mode,
	output logic                        tx_change_tick,
	output logic [11:0]                 baud_divisor
);
	logic [3:0]  div_hi_r;
	logic [7:0]  div_lo_r;
	logic [11:0] cnt_r;
	logic        enable;
	logic        base_tick;
	logic [3:0]  tx_cnt_r;
	logic [3:0]  rx_cnt_r;
	logic [3:0]  tx_last;
	logic [3:0]  rx_last;
	logic        xck_meta_r;
	logic        xck_sync_r;
	logic        xck_prev_r;
	logic [2:0]  xck_arm_r;
	logic        xck_rise;
	logic        xck_fall;
	logic        xck_out_r;
	logic        master_rise;
	logic        master_fall;
	logic        sample_edge;
	logic        change_edge;
	ucgen_pkg::ucg_ticks_type ticks_r;
	logic        tx_change_r;

	function automatic ucgen_pkg::ucg_mode_type decode_mode(input ucgen_pkg::ucg_cfg_type c);
		if (!c.sync_select_bit) begin
			decode_mode = c.double_speed_bit ? ucgen_pkg::UCG_ASYNC_DOUBLE
				: ucgen_pkg::UCG_ASYNC_NORMAL;
		end else begin
			decode_mode = c.xfer_clk_dir_bit ? ucgen_pkg::UCG_SYNC_MASTER
				: ucgen_pkg::UCG_SYNC_SLAVE;
		end
	endfunction

	assign mode         = decode_mode(cfg);
	assign enable       = !cfg.serial_power_off_bit;
	assign baud_divisor = {div_hi_r, div_lo_r};

	// divisor bytes
	always_ff @(posedge mclk) begin
		if (srst) begin
			div_hi_r <= ucgen_pkg::DIV_RST[11:8];
			div_lo_r <= ucgen_pkg::DIV_RST[7:0];
		end else begin
			if (baud_divisor_high_wr) begin
				div_hi_r <= wr_data[3:0];
			end
			if (baud_divisor_low_wr) begin
				div_lo_r <= wr_data;
			end
		end
	end

	// baud down-counter
	assign base_tick = enable && (cnt_r == 12'h0000);
	always_ff @(posedge mclk) begin
		if (srst || !enable) begin
			cnt_r <= ucgen_pkg::DIV_RST;
		end else if (baud_divisor_low_wr) begin
			cnt_r <= {div_hi_r, wr_data};
		end else if (cnt_r == 12'h0000) begin
			cnt_r <= baud_divisor;
		end else begin
			cnt_r <= cnt_r - 12'h001;
		end
	end

	// division per mode
	always_comb begin
		unique case (mode)
			ucgen_pkg::UCG_ASYNC_NORMAL: begin
				tx_last = ucgen_pkg::TX_DIV_NORM;
				rx_last = ucgen_pkg::RX_ST_NORM;
			end
			ucgen_pkg::UCG_ASYNC_DOUBLE: begin
				tx_last = ucgen_pkg::TX_DIV_DOUBLE;
				rx_last = ucgen_pkg::RX_ST_DOUBLE;
			end
			ucgen_pkg::UCG_SYNC_MASTER: begin
				tx_last = ucgen_pkg::TX_DIV_MASTER;
				rx_last = ucgen_pkg::RX_ST_MASTER;
			end
			ucgen_pkg::UCG_SYNC_SLAVE: begin
				tx_last = ucgen_pkg::TX_DIV_MASTER;
				rx_last = ucgen_pkg::RX_ST_MASTER;
			end
		endcase
	end

	// transmit divider
	always_ff @(posedge mclk) begin
		if (srst || !enable || mode == ucgen_pkg::UCG_SYNC_SLAVE) begin
			tx_cnt_r <= 4'h0;
		end else if (base_tick) begin
			tx_cnt_r <= (tx_cnt_r >= tx_last) ? 4'h0 : tx_cnt_r + 4'h1;
		end
	end

	// receive recovery phase
	always_ff @(posedge mclk) begin
		if (srst || !enable || mode == ucgen_pkg::UCG_SYNC_SLAVE) begin
			rx_cnt_r <= 4'h0;
		end else if (base_tick) begin
			rx_cnt_r <= (rx_cnt_r >= rx_last) ? 4'h0 : rx_cnt_r + 4'h1;
		end
	end

	// pin synchroniser and edge detector, slave only
	always_ff @(posedge mclk) begin
		if (srst) begin
			xck_meta_r <= 1'b0;
			xck_sync_r <= 1'b0;
			xck_prev_r <= 1'b0;
			xck_arm_r  <= 3'h0;
		end else begin
			xck_meta_r <= xfer_clk_pin_in;
			xck_sync_r <= xck_meta_r;
			xck_prev_r <= xck_sync_r;
			xck_arm_r  <= {xck_arm_r[1:0], 1'b1};
		end
	end
	// remote clock is assumed below a quarter of mclk
	// edges are ignored until the chain holds real pin samples, so an idle-high pin
	// gives no false edge after reset
	assign xck_rise = xck_arm_r[2] && xck_sync_r && !xck_prev_r;
	assign xck_fall = xck_arm_r[2] && !xck_sync_r && xck_prev_r;

	// master clock output toggles each base tick; edges are named as seen on the pin
	assign master_rise = base_tick && !(xck_out_r ^ cfg.clk_polarity_bit);
	assign master_fall = base_tick && (xck_out_r ^ cfg.clk_polarity_bit);
	always_ff @(posedge mclk) begin
		if (srst || !enable || mode != ucgen_pkg::UCG_SYNC_MASTER) begin
			xck_out_r <= 1'b0;
		end else if (base_tick) begin
			xck_out_r <= !xck_out_r;
		end
	end

	// sync sample/change edge selection
	always_comb begin
		sample_edge = 1'b0;
		change_edge = 1'b0;
		if (mode == ucgen_pkg::UCG_SYNC_MASTER) begin
			sample_edge = cfg.clk_polarity_bit ? master_rise : master_fall;
			change_edge = cfg.clk_polarity_bit ? master_fall : master_rise;
		end else if (mode == ucgen_pkg::UCG_SYNC_SLAVE && enable) begin
			sample_edge = cfg.clk_polarity_bit ? xck_rise : xck_fall;
			change_edge = cfg.clk_polarity_bit ? xck_fall : xck_rise;
		end
	end

	// registered tick outputs
	always_ff @(posedge mclk) begin
		if (srst) begin
			ticks_r     <= '0;
			tx_change_r <= 1'b0;
		end else if (!cfg.sync_select_bit) begin
			ticks_r.baud_tick      <= base_tick;
			ticks_r.tx_bit_tick    <= base_tick && (tx_cnt_r == tx_last);
			ticks_r.rx_sample_tick <= base_tick && (rx_cnt_r == (rx_last >> 1));
			ticks_r.rx_recov_tick  <= base_tick;
			ticks_r.rx_phase       <= rx_cnt_r;
			tx_change_r            <= base_tick && (tx_cnt_r == tx_last);
		end else begin
			ticks_r.baud_tick      <= base_tick;
			ticks_r.tx_bit_tick    <= change_edge;
			ticks_r.rx_sample_tick <= sample_edge;
			ticks_r.rx_recov_tick  <= sample_edge;
			ticks_r.rx_phase       <= 4'h0;
			tx_change_r            <= change_edge;
		end
	end

	assign ticks            = ticks_r;
	assign tx_change_tick   = tx_change_r;
	assign xfer_clk_pin_out = xck_out_r ^ cfg.clk_polarity_bit;
	assign xfer_clk_pin_oe  = enable && (mode == ucgen_pkg::UCG_SYNC_MASTER);
endmodule

// >>> src/ucgen_pkg.sv
// package: constants and carrier types for the serial clock generator
package ucgen_pkg;
	localparam int DIV_W            = 12;
	localparam logic [11:0] DIV_RST = 12'h0000;
	localparam logic [3:0] TX_DIV_NORM   = 4'hf;
	localparam logic [3:0] TX_DIV_DOUBLE = 4'h7;
	localparam logic [3:0] TX_DIV_MASTER = 4'h1;
	localparam logic [3:0] RX_ST_NORM    = 4'hf;
	localparam logic [3:0] RX_ST_DOUBLE  = 4'h7;
	localparam logic [3:0] RX_ST_MASTER  = 4'h1;

	typedef enum logic [1:0] {
		UCG_ASYNC_NORMAL,
		UCG_ASYNC_DOUBLE,
		UCG_SYNC_MASTER,
		UCG_SYNC_SLAVE
	} ucg_mode_type;

	typedef struct packed {
		logic        sync_select_bit;
		logic        double_speed_bit;
		logic        xfer_clk_dir_bit;
		logic        clk_polarity_bit;
		logic        serial_power_off_bit;
	} ucg_cfg_type;

	typedef struct packed {
		logic       baud_tick;
		logic       tx_bit_tick;
		logic       rx_sample_tick;
		logic       rx_recov_tick;
		logic [3:0] rx_phase;
	} ucg_ticks_type;
endpackage
